//--- rtl/sspc_cfg.svh
// Offsets, field positions, reset values and divider counts of the serial port control block.
`ifndef SSPC_CFG_SVH
`define SSPC_CFG_SVH
`define SSPC_OFS_CTRL    8'h00
`define SSPC_OFS_DATA    8'h04
`define SSPC_OFS_ISTAT   8'h08
`define SSPC_OFS_IEN     8'h0C
`define SSPC_OFS_ICLR    8'h10
`define SSPC_OFS_PINCFG  8'h14
`define SSPC_OFS_PINLVL  8'h18
`define SSPC_BIT_WRITE_COLLISION_FLAG    7
`define SSPC_BIT_OVF     6
`define SSPC_BIT_EN      5
`define SSPC_BIT_CKP     4
`define SSPC_CTRL_RST    8'h00
`define SSPC_PINCFG_RST  8'h00
`define SSPC_IRQ_DONE    0
`define SSPC_IRQ_WRITE_COLLISION_FLAG    1
`define SSPC_IRQ_OVF     2
`define SSPC_MODE_SPIM4  4'h0
`define SSPC_MODE_SPIM16 4'h1
`define SSPC_MODE_SPIM64 4'h2
`define SSPC_MODE_SPISS  4'h4
`define SSPC_MODE_SPISN  4'h5
`define SSPC_MODE_I2CM   4'h8
`define SSPC_MODE_I2CFM  4'hB
`define SSPC_HALF_DIV4   6'h02
`define SSPC_HALF_DIV16  6'h08
`define SSPC_HALF_DIV64  6'h20
`define SSPC_PIN_SCK     0
`define SSPC_PIN_SDO     1
`define SSPC_PIN_SDI     2
`define SSPC_PIN_SS      3
`endif

//--- rtl/sspc_pkg.sv
// Types shared by the serial port control modules.
package sspc_pkg;
  typedef enum logic [2:0] {PR_OFF, PR_SPIM, PR_SPIS, PR_I2CS, PR_I2CM} sspc_proto_type;
  typedef enum logic [1:0] {MS_IDLE, MS_SETUP, MS_HOLD} sspc_mst_state_type;
endpackage

//--- rtl/sspc_if.sv
// Internal register access channel between the bus slave and the core.
interface sspc_if;
  logic       wrEn;
  logic       rdEn;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport bus
  (
    output wrEn,
    output rdEn,
    output addr,
    output wdata,
    input  rdata
  );
  modport core
  (
    input  wrEn,
    input  rdEn,
    input  addr,
    input  wdata,
    output rdata
  );
endinterface

//--- rtl/sspc_wb_slave.sv
// Classic Wishbone slave that turns bus cycles into register strobes.
module sspc_wb_slave #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rstSyncN,
  // Wishbone.
  input  wire logic              cyc,
  input  wire logic              stb,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] adr,
  input  wire logic [3:0]        sel,
  input  wire logic [31:0]       wrData,
  output logic                   ack,
  output logic [31:0]            rdData,
  // Register channel.
  sspc_if.bus                    regs
);
  logic ack_ff;
  logic [31:0] rdData_ff;

  assign ack = ack_ff;
  assign rdData = rdData_ff;
  assign regs.addr = adr[7:0];
  assign regs.wdata = wrData[7:0];
  assign regs.wrEn = cyc && stb && we && ack_ff && sel[0];
  assign regs.rdEn = cyc && stb && !we && ack_ff;

  // Acknowledge one cycle after the request is seen.
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      ack_ff <= 1'b0;
    else
      ack_ff <= cyc && stb && !ack_ff;
  end

  // Capture read data with the acknowledge.
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      rdData_ff <= 32'h00000000;
    else if (cyc && stb && !ack_ff)
      rdData_ff <= {24'h000000, regs.rdata};
  end
endmodule

//--- rtl/sspc_pin_mux.sv
// Registered pin multiplexer between the general-purpose port and the serial logic.
`include "sspc_cfg.svh"
module sspc_pin_mux #(
  parameter int NPINS = 4
) (
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    rstSyncN,
  // Selection.
  input  wire sspc_pkg::sspc_proto_type proto,
  // Serial side.
  input  wire logic [NPINS-1:0]        serOut,
  input  wire logic [NPINS-1:0]        serOe,
  // Port side.
  input  wire logic [NPINS-1:0]        gpioOut,
  input  wire logic [NPINS-1:0]        gpioOe,
  // Pads.
  output logic [NPINS-1:0]             pinOut,
  output logic [NPINS-1:0]             pinOe
);
  import sspc_pkg::*;

  if (NPINS != 4)
  begin : gBadPins
    $error("sspc_pin_mux supports exactly four pins");
  end

  for (genvar i = 0; i < NPINS; i++)
  begin : gPin
    localparam bit I2C_PIN = (i == `SSPC_PIN_SCK) || (i == `SSPC_PIN_SDI);
    always_ff @(posedge clk or negedge rstSyncN)
    begin
      if (!rstSyncN)
      begin
        pinOut[i] <= 1'b0;
        pinOe[i] <= 1'b0;
      end
      else if (proto == PR_SPIM || proto == PR_SPIS)
      begin
        pinOut[i] <= serOut[i];
        pinOe[i] <= gpioOe[i];
      end
      else if ((proto == PR_I2CS || proto == PR_I2CM) && I2C_PIN)
      begin
        pinOut[i] <= 1'b0;
        pinOe[i] <= serOe[i];
      end
      else
      begin
        pinOut[i] <= gpioOut[i];
        pinOe[i] <= gpioOe[i];
      end
    end
  end
endmodule

//--- rtl/sspc_top.sv
// Control register, shifter and pin hand-over of the synchronous serial port.
// Functional notes
// - SPI slave: write while shifting sets collision.
// - SPI slave: full buffer overflows, byte dropped.
// - SPI master never overflows; I2C overflows too.
// - Enabled SPI drives four pin levels; port setting keeps the enables.
// - Enabled I2C hands data, clock over.
// - Disabled port returns pins to port.
// - Polarity bit sets SPI idle clock level.
// - I2C slave stretches clock while bit clear.
// - Mode zero: SPI master, clock divided four.
//
// Decided for this implementation: the placing of the registers and the Wishbone register port.
`include "sspc_cfg.svh"
module sspc_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rstn,
  // Wishbone.
  input  wire logic              cyc,
  input  wire logic              stb,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] adr,
  input  wire logic [3:0]        sel,
  input  wire logic [31:0]       wrData,
  output logic                   ack,
  output logic [31:0]            rdData,
  // Pins.
  input  wire logic [3:0]        pinIn,
  output logic [3:0]             pinOut,
  output logic [3:0]             pinOe,
  // Interrupt.
  output logic                   irq
);
  import sspc_pkg::*;

  if (ADDR_W < 8)
  begin : gBadAddr
    $error("sspc_top needs at least eight address bits");
  end

  logic [1:0]         rstPipe_ff;
  logic [3:0]         mode_ff, bitCnt_ff, pinPrev_ff, gpioOut_ff, gpioOe_ff, serOut, serOe;
  logic [5:0]         divCnt_ff, halfDiv;
  logic [7:0]         rxBuf_ff, shift_ff, newByte;
  logic [2:0]         irqStat_ff, irqEn_ff, irqEvents;
  logic               rstSyncN, en_ff, ckp_ff, write_collision_flag_ff, ovf_ff, rxFull_ff, sample_ff, i2cBusy_ff, irq_ff, ctrlWr;
  logic               dataWr, dataRd, divEnd, mLead, mTrail, slaveSel, sckEdge, sLead, sTrail, spiLead, spiTrail;
  logic               slaveBusy, sclRise, i2cStart, i2cStop, i2cBit, byteDone, wcolSet, ovfSet, loadTx;
  sspc_mst_state_type mstState_ff;
  sspc_proto_type     proto;

  sspc_if regBus ();

  // Reset release through two flip-flops.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rstPipe_ff <= 2'h0;
    else
      rstPipe_ff <= {rstPipe_ff[0], 1'b1};
  end
  assign rstSyncN = rstPipe_ff[1];

  sspc_wb_slave #(
    .ADDR_W (ADDR_W)
  ) uBus (
    .clk      (clk),
    .rstSyncN (rstSyncN),
    .cyc      (cyc),
    .stb      (stb),
    .we       (we),
    .adr      (adr),
    .sel      (sel),
    .wrData   (wrData),
    .ack      (ack),
    .rdData   (rdData),
    .regs     (regBus.bus)
  );

  assign ctrlWr = regBus.wrEn && (regBus.addr == `SSPC_OFS_CTRL);
  assign dataWr = regBus.wrEn && (regBus.addr == `SSPC_OFS_DATA);
  assign dataRd = regBus.rdEn && (regBus.addr == `SSPC_OFS_DATA);

  // Protocol and role from the enable bit and mode field.
  always_comb
  begin
    proto = PR_OFF;
    halfDiv = `SSPC_HALF_DIV4;
    if (en_ff)
    begin
      case (mode_ff)
        `SSPC_MODE_SPIM4: proto = PR_SPIM;
        `SSPC_MODE_SPIM16:
        begin
          proto = PR_SPIM;
          halfDiv = `SSPC_HALF_DIV16;
        end
        `SSPC_MODE_SPIM64:
        begin
          proto = PR_SPIM;
          halfDiv = `SSPC_HALF_DIV64;
        end
        `SSPC_MODE_SPISS, `SSPC_MODE_SPISN: proto = PR_SPIS;
        `SSPC_MODE_I2CM, `SSPC_MODE_I2CFM: proto = PR_I2CM;
        default: proto = (mode_ff[2:1] == 2'b11) ? PR_I2CS : PR_OFF;
      endcase
    end
  end

  // Master clock phases.
  assign divEnd = (divCnt_ff == halfDiv - 6'h01);
  assign mLead = (mstState_ff == MS_SETUP) && divEnd;
  assign mTrail = (mstState_ff == MS_HOLD) && divEnd;

  // Slave clock edges relative to the idle level.
  assign slaveSel = (mode_ff == `SSPC_MODE_SPISN) || !pinIn[`SSPC_PIN_SS];
  assign sckEdge = slaveSel && (pinIn[`SSPC_PIN_SCK] != pinPrev_ff[`SSPC_PIN_SCK]);
  assign sLead = sckEdge && (pinIn[`SSPC_PIN_SCK] != ckp_ff);
  assign sTrail = sckEdge && (pinIn[`SSPC_PIN_SCK] == ckp_ff);
  assign spiLead = ((proto == PR_SPIM) && mLead) || ((proto == PR_SPIS) && sLead);
  assign spiTrail = ((proto == PR_SPIM) && mTrail) || ((proto == PR_SPIS) && sTrail);
  assign slaveBusy = (bitCnt_ff != 4'h0) || (slaveSel && (pinIn[`SSPC_PIN_SCK] != ckp_ff));

  // I2C bus conditions.
  assign sclRise = pinIn[`SSPC_PIN_SCK] && !pinPrev_ff[`SSPC_PIN_SCK];
  assign i2cStart = pinIn[`SSPC_PIN_SCK] && pinPrev_ff[`SSPC_PIN_SCK]
                    && pinPrev_ff[`SSPC_PIN_SDI] && !pinIn[`SSPC_PIN_SDI];
  assign i2cStop = pinIn[`SSPC_PIN_SCK] && pinPrev_ff[`SSPC_PIN_SCK]
                   && !pinPrev_ff[`SSPC_PIN_SDI] && pinIn[`SSPC_PIN_SDI];
  assign i2cBit = (proto == PR_I2CS || proto == PR_I2CM) && i2cBusy_ff && sclRise && !i2cStart;

  assign byteDone = (spiTrail || i2cBit) && (bitCnt_ff == 4'h7);
  assign newByte = spiTrail ? {shift_ff[6:0], sample_ff} : {shift_ff[6:0], pinIn[`SSPC_PIN_SDI]};

  // Collision detection on buffer writes.
  always_comb
  begin
    wcolSet = 1'b0;
    case (proto)
      PR_SPIS: wcolSet = dataWr && slaveBusy;
      PR_SPIM: wcolSet = dataWr && (mstState_ff != MS_IDLE);
      PR_I2CM: wcolSet = dataWr && i2cBusy_ff;
      default: wcolSet = 1'b0;
    endcase
  end

  assign ovfSet = byteDone && rxFull_ff && !dataRd && (proto != PR_SPIM);
  assign loadTx = dataWr && !wcolSet && (proto == PR_SPIM || proto == PR_SPIS);

  // Control register; hardware set wins over software clear.
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      en_ff <= 1'(`SSPC_CTRL_RST >> `SSPC_BIT_EN);
      ckp_ff <= 1'b0;
      mode_ff <= 4'h0;
      write_collision_flag_ff <= 1'b0;
      ovf_ff <= 1'b0;
    end
    else
    begin
      if (ctrlWr)
      begin
        en_ff <= regBus.wdata[`SSPC_BIT_EN];
        ckp_ff <= regBus.wdata[`SSPC_BIT_CKP];
        mode_ff <= regBus.wdata[3:0];
      end
      write_collision_flag_ff <= wcolSet || (write_collision_flag_ff && !(ctrlWr && !regBus.wdata[`SSPC_BIT_WRITE_COLLISION_FLAG]));
      ovf_ff <= ovfSet || (ovf_ff && !(ctrlWr && !regBus.wdata[`SSPC_BIT_OVF]));
    end
  end

  // Receive buffer.
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      rxBuf_ff <= 8'h00;
      rxFull_ff <= 1'b0;
    end
    else if (byteDone && !ovfSet)
    begin
      rxBuf_ff <= newByte;
      rxFull_ff <= 1'b1;
    end
    else if (dataRd)
      rxFull_ff <= 1'b0;
  end

  // Shift register and bit counter.
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      shift_ff <= 8'h00;
      bitCnt_ff <= 4'h0;
      sample_ff <= 1'b0;
    end
    else if (proto == PR_OFF)
      bitCnt_ff <= 4'h0;
    else if (loadTx)
    begin
      shift_ff <= regBus.wdata;
      bitCnt_ff <= 4'h0;
    end
    else if (spiLead)
      sample_ff <= pinIn[`SSPC_PIN_SDI];
    else if (spiTrail)
    begin
      shift_ff <= newByte;
      bitCnt_ff <= (bitCnt_ff == 4'h7) ? 4'h0 : bitCnt_ff + 4'h1;
    end
    else if (i2cStart)
      bitCnt_ff <= 4'h0;
    else if (i2cBit)
    begin
      if (bitCnt_ff == 4'h8)
        bitCnt_ff <= 4'h0;
      else
      begin
        shift_ff <= newByte;
        bitCnt_ff <= bitCnt_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      mstState_ff <= MS_IDLE;
      divCnt_ff <= 6'h00;
    end
    else if (proto != PR_SPIM)
    begin
      mstState_ff <= MS_IDLE;
      divCnt_ff <= 6'h00;
    end
    else
    begin
      case (mstState_ff)
        MS_IDLE:
          if (loadTx)
            mstState_ff <= MS_SETUP;
        MS_SETUP, MS_HOLD:
        begin
          divCnt_ff <= divEnd ? 6'h00 : divCnt_ff + 6'h01;
          if (divEnd && mstState_ff == MS_SETUP)
            mstState_ff <= MS_HOLD;
          else if (divEnd)
            mstState_ff <= (bitCnt_ff == 4'h7) ? MS_IDLE : MS_SETUP;
        end
        default: mstState_ff <= MS_IDLE;
      endcase
    end
  end

  // Pin history and I2C bus busy tracking.
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      pinPrev_ff <= 4'hF;
      i2cBusy_ff <= 1'b0;
    end
    else
    begin
      pinPrev_ff <= pinIn;
      if (proto != PR_I2CS && proto != PR_I2CM)
        i2cBusy_ff <= 1'b0;
      else if (i2cStart)
        i2cBusy_ff <= 1'b1;
      else if (i2cStop)
        i2cBusy_ff <= 1'b0;
    end
  end

  // Serial drive towards the pin multiplexer.
  always_comb
  begin
    serOut = 4'h0;
    serOe = 4'h0;
    serOut[`SSPC_PIN_SCK] = ckp_ff ^ (mstState_ff == MS_HOLD);
    serOut[`SSPC_PIN_SDO] = shift_ff[7];
    serOe[`SSPC_PIN_SCK] = (proto == PR_I2CS) && !ckp_ff;
  end

  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      gpioOut_ff <= 4'(`SSPC_PINCFG_RST);
      gpioOe_ff <= 4'h0;
    end
    else if (regBus.wrEn && regBus.addr == `SSPC_OFS_PINCFG)
    begin
      gpioOut_ff <= regBus.wdata[3:0];
      gpioOe_ff <= regBus.wdata[7:4];
    end
  end

  sspc_pin_mux #(
    .NPINS (4)
  ) uPins (
    .clk      (clk),
    .rstSyncN (rstSyncN),
    .proto    (proto),
    .serOut   (serOut),
    .serOe    (serOe),
    .gpioOut  (gpioOut_ff),
    .gpioOe   (gpioOe_ff),
    .pinOut   (pinOut),
    .pinOe    (pinOe)
  );

  // Interrupt status, enable and clear.
  assign irqEvents = {ovfSet, wcolSet, byteDone};
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      irqStat_ff <= 3'h0;
      irqEn_ff <= 3'h0;
      irq_ff <= 1'b0;
    end
    else
    begin
      if (regBus.wrEn && regBus.addr == `SSPC_OFS_ICLR)
        irqStat_ff <= (irqStat_ff & ~regBus.wdata[2:0]) | irqEvents;
      else
        irqStat_ff <= irqStat_ff | irqEvents;
      if (regBus.wrEn && regBus.addr == `SSPC_OFS_IEN)
        irqEn_ff <= regBus.wdata[2:0];
      irq_ff <= |(irqStat_ff & irqEn_ff);
    end
  end
  assign irq = irq_ff;

  // Register read multiplexer.
  always_comb
  begin
    case (regBus.addr)
      `SSPC_OFS_CTRL: regBus.rdata = {write_collision_flag_ff, ovf_ff, en_ff, ckp_ff, mode_ff};
      `SSPC_OFS_DATA: regBus.rdata = rxBuf_ff;
      `SSPC_OFS_ISTAT: regBus.rdata = {5'h00, irqStat_ff};
      `SSPC_OFS_IEN: regBus.rdata = {5'h00, irqEn_ff};
      `SSPC_OFS_PINCFG: regBus.rdata = {gpioOe_ff, gpioOut_ff};
      `SSPC_OFS_PINLVL: regBus.rdata = {4'h0, pinIn};
      default: regBus.rdata = 8'h00;
    endcase
  end
endmodule

//--- verif/sspc_checker.sv
// Concurrent checks on the ports of the serial port control top.
`include "sspc_cfg.svh"
module sspc_checker #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic              clk,
  input wire logic              rstn,
  // Wishbone.
  input wire logic              cyc,
  input wire logic              stb,
  input wire logic              we,
  input wire logic [ADDR_W-1:0] adr,
  input wire logic [3:0]        sel,
  input wire logic [31:0]       wrData,
  input wire logic              ack,
  input wire logic [31:0]       rdData,
  // Pins and interrupt.
  input wire logic [3:0]        pinIn,
  input wire logic [3:0]        pinOut,
  input wire logic [3:0]        pinOe,
  input wire logic              irq
);
  logic [7:0] ctrl_ff;
  logic [7:0] pinCfg_ff;
  logic [1:0] quiet_ff;
  logic       wrAck;
  logic [3:0] md;
  logic       en;
  logic       clock_polarity_bit;
  logic       spiMd;
  logic       i2cSl;
  logic       i2cMd;
  logic       q3;
  assign wrAck = cyc && stb && we && ack && sel[0];
  assign md = ctrl_ff[3:0];
  assign en = ctrl_ff[`SSPC_BIT_EN];
  assign clock_polarity_bit = ctrl_ff[`SSPC_BIT_CKP];
  assign q3 = quiet_ff == 2'h3;
  assign spiMd = md < 4'h3 || md == 4'h4 || md == 4'h5;
  assign i2cSl = md == 4'h6 || md == 4'h7 || md == 4'hE || md == 4'hF;
  assign i2cMd = i2cSl || md == 4'h8 || md == 4'hB;
  // Shadow of the control and pin setting registers.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ctrl_ff <= 8'h00;
    else if (wrAck && adr[7:0] == `SSPC_OFS_CTRL)
      ctrl_ff <= wrData[7:0];
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pinCfg_ff <= 8'h00;
    else if (wrAck && adr[7:0] == `SSPC_OFS_PINCFG)
      pinCfg_ff <= wrData[7:0];
  end
  // Counts edges since the pin selection last changed.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      quiet_ff <= 2'h0;
    else if (wrAck && (adr[7:0] == `SSPC_OFS_CTRL || adr[7:0] == `SSPC_OFS_PINCFG))
      quiet_ff <= 2'h0;
    else if (!q3)
      quiet_ff <= quiet_ff + 2'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_ack_pulse: assert property (ack |=> !ack) else $error("ack longer than one cycle");
  chk_ack_next: assert property (cyc && stb && !ack |=> ack) else $error("ack not one cycle after request");
  chk_rd_upper: assert property (ack |-> rdData[31:8] == 24'h0) else $error("read data upper bits set");
  chk_rd_unmapped: assert property (ack && !we && (adr[7:0] > 8'h18 || adr[7:0] == `SSPC_OFS_ICLR)
    |-> rdData == 32'h0) else $error("unmapped read not zero");
  chk_spi_pins: assert property (en && spiMd && q3 |-> pinOe == pinCfg_ff[7:4])
    else $error("SPI pin enables differ from setting");
  chk_i2c_pins: assert property (en && i2cMd && q3 |-> !pinOe[2] && !pinOut[0] && !pinOut[2])
    else $error("I2C lines not open drain");
  chk_port_pins: assert property (!en && q3 |-> pinOe == pinCfg_ff[7:4] && pinOut == pinCfg_ff[3:0])
    else $error("disabled pins differ from port setting");
  chk_clk_stretch: assert property (en && i2cSl && q3 |-> pinOe[0] == !clock_polarity_bit)
    else $error("clock stretch differs from polarity bit");
  chk_sck_half: assert property (en && md == 4'h0 && q3 && $past(pinOut[0]) == clock_polarity_bit && pinOut[0] != clock_polarity_bit
    |=> pinOut[0] != clock_polarity_bit ##1 pinOut[0] == clock_polarity_bit) else $error("clock active phase not two cycles");
endmodule
bind sspc_top sspc_checker #(.ADDR_W(ADDR_W)) u_sspc_checker (.clk(clk), .rstn(rstn), .cyc(cyc), .stb(stb),
  .we(we), .adr(adr), .sel(sel), .wrData(wrData), .ack(ack), .rdData(rdData), .pinIn(pinIn), .pinOut(pinOut),
  .pinOe(pinOe), .irq(irq));

//--- verif/sspc_peer.sv
// Bus peer that clocks the port as SPI master or marks an I2C start.
module sspc_peer (
  // Clock.
  input  wire logic clk,
  // Lines towards the port.
  output logic      sck,
  output logic      sdi,
  output logic      ssN,
  input  wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sck = 1'b0;
    sdi = 1'b0;
    ssN = 1'b1;
  end
  task automatic waitClk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One byte, most significant bit first; released data shows its inverse.
  task automatic xfer(input logic cpol, input logic [7:0] tx, output logic [7:0] rx);
    sck <= cpol;
    ssN <= 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      sdi <= tx[i];
      waitClk(4);
      rx[i] = sdo;
      sck <= ~cpol;
      waitClk(4);
      sck <= cpol;
      waitClk(4);
    end
    ssN <= 1'b1;
    sdi <= ~tx[0];
  endtask
  // Data falls while the clock line is high.
  task automatic startCond();
    sck <= 1'b1;
    sdi <= 1'b1;
    waitClk(8);
    sdi <= 1'b0;
    waitClk(8);
  endtask
endmodule

//--- verif/tb.sv
// Self-checking bench of the serial port control block.
`include "sspc_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wrData = 32'h0;
  logic        ack;
  logic [31:0] rdData;
  logic [3:0]  pinOut;
  logic [3:0]  pinOe;
  logic        irq;
  logic        sck;
  logic        sdi;
  logic        ssN;
  logic [7:0]  rx;
  logic        oeSeen;
  int          failures = 0;
  int          samplesChecked = 0;
  logic [23:0] rows [7] = '{24'h00_05_05, 24'h14_A5_A5, 24'h0C_07_07, 24'h10_07_00, 24'h08_FF_00,
                            24'h1C_5A_00, 24'h18_0F_0A};
  always #2.5 clk = ~clk;
  sspc_peer u_sspc_peer (.clk(clk), .sck(sck), .sdi(sdi), .ssN(ssN), .sdo(pinOut[`SSPC_PIN_SDO]));
  sspc_top u_sspc_top (.clk(clk), .rstn(rstn), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .wrData(wrData), .ack(ack), .rdData(rdData), .pinIn({ssN, sdi, 1'b1, sck}), .pinOut(pinOut),
    .pinOe(pinOe), .irq(irq));
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    samplesChecked++;
    if (s !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wrData <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    r = rdData;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1)
    begin
      failures++;
      close_out();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, a, {24'h0, d}, r);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    check(n, r, e);
  endtask
  task automatic pollDone();
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < 300 && v[0] !== 1'b1; i++)
      wb(1'b0, `SSPC_OFS_ISTAT, 32'h0, v);
    check("done", v[0], 1'b1);
  endtask
  initial
  begin
    #200000;
    failures++;
    close_out();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rows[i])
    begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd("row", rows[i][23:16], {24'h0, rows[i][7:0]});
    end
    ticks(3);
    check("port pins", {pinOe, pinOut}, 8'hA5);
    wr(`SSPC_OFS_PINCFG, 8'h30);
    for (int k = 0; k < 2; k++)
    begin
      wr(`SSPC_OFS_CTRL, 8'h20 | 8'(k << 4));
      ticks(4);
      check("sck idle", pinOut[`SSPC_PIN_SCK], k[0]);
    end
    wr(`SSPC_OFS_DATA, 8'h81);
    pollDone();
    wr(`SSPC_OFS_ICLR, 8'h01);
    wr(`SSPC_OFS_DATA, 8'h42);
    pollDone();
    rd("master ctrl", `SSPC_OFS_CTRL, 32'h30);
    rd("master stat", `SSPC_OFS_ISTAT, 32'h01);
    for (int m = 1; m < 3; m++)
    begin
      wr(`SSPC_OFS_ICLR, 8'h01);
      wr(`SSPC_OFS_CTRL, 8'h30 | 8'(m));
      wr(`SSPC_OFS_DATA, 8'h42);
      pollDone();
      rd("div ctrl", `SSPC_OFS_CTRL, 32'h30 | m);
    end
    wr(`SSPC_OFS_PINCFG, 8'h20);
    wr(`SSPC_OFS_CTRL, 8'h24);
    rd("drain", `SSPC_OFS_DATA, 32'h00);
    wr(`SSPC_OFS_ICLR, 8'h07);
    wr(`SSPC_OFS_DATA, 8'h3C);
    u_sspc_peer.xfer(1'b0, 8'hA6, rx);
    check("slave tx", rx, 8'h3C);
    rd("slave stat", `SSPC_OFS_ISTAT, 32'h01);
    fork
      u_sspc_peer.xfer(1'b0, 8'h5A, rx);
      begin
        ticks(20);
        wr(`SSPC_OFS_DATA, 8'h11);
      end
    join
    rd("flags", `SSPC_OFS_CTRL, 32'hE4);
    rd("flag stat", `SSPC_OFS_ISTAT, 32'h07);
    rd("kept byte", `SSPC_OFS_DATA, 32'hA6);
    check("irq on", irq, 1'b1);
    wr(`SSPC_OFS_IEN, 8'h00);
    ticks(2);
    check("irq masked", irq, 1'b0);
    wr(`SSPC_OFS_IEN, 8'h07);
    ticks(2);
    check("irq again", irq, 1'b1);
    wr(`SSPC_OFS_ICLR, 8'h07);
    ticks(2);
    check("irq cleared", irq, 1'b0);
    wr(`SSPC_OFS_CTRL, 8'h24);
    rd("flags clear", `SSPC_OFS_CTRL, 32'h24);
    wr(`SSPC_OFS_CTRL, 8'h26);
    ticks(4);
    check("stretch", {pinOe[0], pinOut[0]}, 2'b10);
    wr(`SSPC_OFS_CTRL, 8'h36);
    ticks(4);
    check("release", pinOe[0], 1'b0);
    wr(`SSPC_OFS_CTRL, 8'h28);
    ticks(4);
    oeSeen = pinOe[0];
    wr(`SSPC_OFS_CTRL, 8'h38);
    ticks(4);
    check("master scl", pinOe[0], oeSeen);
    check("master no stretch", oeSeen, 1'b0);
    check("sda free", pinOe[2], 1'b0);
    u_sspc_peer.startCond();
    wr(`SSPC_OFS_DATA, 8'h55);
    rd("busy write", `SSPC_OFS_CTRL, 32'hB8);
    rstn <= 1'b0;
    ticks(2);
    check("reset outs", {ack, irq, pinOe, pinOut}, 10'h0);
    check("reset rd", rdData, 32'h0);
    ticks(3);
    @(posedge clk);
    rstn <= 1'b1;
    ticks(3);
    rd("ctrl reset", `SSPC_OFS_CTRL, {24'h0, `SSPC_CTRL_RST});
    rd("pincfg reset", `SSPC_OFS_PINCFG, {24'h0, `SSPC_PINCFG_RST});
    close_out();
  end
endmodule
